// >>> shared/rst_gate_pkg.sv
// Shared constants and types for the reset and clock gating block
package rst_gate_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] PCG_OFF  = 8'h00;
    localparam logic [7:0] CFG_OFF  = 8'h04;
    localparam logic [7:0] STAT_OFF = 8'h08;

    // ------------------------------------------------------------
    // Bit positions of the gate register
    // ------------------------------------------------------------
    localparam int BIT_TWO_WIRE = 7;
    localparam int BIT_ASYNC_TMR = 6;
    localparam int BIT_BYTE_TMR = 5;
    localparam int BIT_SERIAL1 = 4;
    localparam int BIT_WIDE_TMR = 3;
    localparam int BIT_SPI = 2;
    localparam int BIT_SERIAL0 = 1;
    localparam int BIT_CONVERTER = 0;

    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] PCG_RESET = 8'h00;
    localparam logic [2:0] BOD_OFF   = 3'h7;
    localparam int         CKS_LONG  = 3;

    // Status word fields
    localparam int ST_SRC_LSB  = 0;
    localparam int ST_BUSY     = 4;
    localparam int ST_GATE_LSB = 8;

    // Timing
    localparam int CLK_MHZ = 20;
    localparam int CNT_W   = 24;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] brownout_level_config;
        logic [3:0] clock_source_select;
        logic [1:0] startup_time_select;
    } cfg_type;

    localparam cfg_type CFG_RESET = '{
        brownout_level_config: 3'h7,
        clock_source_select:   4'h0,
        startup_time_select:   2'h2
    };

    typedef struct packed {
        logic por;
        logic ext;
        logic brownout_detector;
        logic scan;
    } src_type;

    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_COUNT = 2'b01,
        ST_RUN   = 2'b10
    } rst_state_type;

endpackage

// >>> verilog/reset_and_module_clock_gating.sv
// Reset combiner, reset stretcher and peripheral clock gating
`timescale 1ns/1ps

module reset_and_module_clock_gating #(
    parameter int DELAY0_US = 1,
    parameter int DELAY1_US = 100,
    parameter int DELAY2_US = 1000,
    parameter int DELAY3_US = 4000
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Reset sources (asynchronous)
    input  wire logic        por_low_i,
    input  wire logic        ext_reset_n_i,
    input  wire logic        bod_low_i,
    input  wire logic        scan_reset_i,
    // Same-clock inputs
    input  wire logic        wdt_timeout_i,
    input  wire logic        wdt_enable_i,
    input  wire logic        timer_async_clock_select_i,
    input  wire logic        comparator_bandgap_select_i,
    input  wire logic        converter_enable_i,
    // Outputs
    output logic             io_reset_n_o,
    output logic             internal_reset_n_o,
    output logic             vector_start_o,
    output logic      [7:0]  clk_en_o,
    output logic      [7:0]  reg_access_en_o,
    output logic             comparator_mux_en_o,
    output logic             bandgap_en_o
);

    // ------------------------------------------------------------
    // Delay table, figures in cycles of the system clock
    // ------------------------------------------------------------
    localparam int D0 = (DELAY0_US * rst_gate_pkg::CLK_MHZ < 1) ? 1
                        : DELAY0_US * rst_gate_pkg::CLK_MHZ;
    localparam int D1 = DELAY1_US * rst_gate_pkg::CLK_MHZ;
    localparam int D2 = DELAY2_US * rst_gate_pkg::CLK_MHZ;
    localparam int D3 = DELAY3_US * rst_gate_pkg::CLK_MHZ;

    localparam logic [rst_gate_pkg::CNT_W-1:0] DC0 = D0[rst_gate_pkg::CNT_W-1:0];
    localparam logic [rst_gate_pkg::CNT_W-1:0] DC1 = D1[rst_gate_pkg::CNT_W-1:0];
    localparam logic [rst_gate_pkg::CNT_W-1:0] DC2 = D2[rst_gate_pkg::CNT_W-1:0];
    localparam logic [rst_gate_pkg::CNT_W-1:0] DC3 = D3[rst_gate_pkg::CNT_W-1:0];

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]                 pcg_r;
    rst_gate_pkg::cfg_type      cfg_r;
    rst_gate_pkg::src_type      raw_src;
    rst_gate_pkg::src_type      meta_r;
    rst_gate_pkg::src_type      sync_r;
    rst_gate_pkg::rst_state_type state_r;
    logic [rst_gate_pkg::CNT_W-1:0] cnt_r;
    logic [rst_gate_pkg::CNT_W-1:0] delay_sel;
    logic [rst_gate_pkg::CNT_W-1:0] delay_m1;
    logic                       wdt_pulse_r;
    logic                       vec_r;
    logic [31:0]                prdata_r;
    logic                       bod_on;
    logic                       async_src;
    logic                       src_any;
    logic                       stretch;
    logic                       wr_en;
    logic                       mapped;
    logic [7:0]                 gate_stop;
    logic [31:0]                stat_word;

    // ------------------------------------------------------------
    // Source synchronisers
    // ------------------------------------------------------------

    // External pin is active low; flip it so all sources read high
    assign raw_src = '{
        por:  por_low_i,
        ext:  ~ext_reset_n_i,
        brownout_detector:  bod_low_i,
        scan: scan_reset_i
    };

    // Two stages per source before the counter logic looks at it
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    meta_r[g] <= 1'b1;
                    sync_r[g] <= 1'b1;
                end else begin
                    meta_r[g] <= raw_src[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Watchdog pulse
    // ------------------------------------------------------------

    // Self-clearing, so a held time-out never widens past one cycle
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wdt_pulse_r <= 1'b0;
        end else begin
            wdt_pulse_r <= wdt_timeout_i & wdt_enable_i & ~wdt_pulse_r;
        end
    end

    // ------------------------------------------------------------
    // Source combination
    // ------------------------------------------------------------

    // Brown-out only counts while the level config selects a level
    assign bod_on = (cfg_r.brownout_level_config != rst_gate_pkg::BOD_OFF);

    // Raw path works with the clock stopped; ports use it directly
    assign async_src = ~reset_n_i | por_low_i | ~ext_reset_n_i
                     | (bod_on & bod_low_i) | scan_reset_i;
    assign io_reset_n_o = ~(async_src | wdt_pulse_r);

    // Synchronised view drives the delay counter
    assign src_any = sync_r.por | sync_r.ext | (bod_on & sync_r.brownout_detector)
                   | sync_r.scan | wdt_pulse_r;

    assign stretch = (state_r != rst_gate_pkg::ST_RUN);
    // The watchdog pulse holds internal reset low in its own cycle;
    // the stretcher only takes over from the next edge
    assign internal_reset_n_o = ~(async_src | wdt_pulse_r | stretch);

    // ------------------------------------------------------------
    // Delay selection
    // ------------------------------------------------------------

    // Crystal-type sources get twice the settle time
    always_comb begin
        case (cfg_r.startup_time_select)
            2'h0:    delay_sel = DC0;
            2'h1:    delay_sel = DC1;
            2'h2:    delay_sel = DC2;
            default: delay_sel = DC3;
        endcase
        if (cfg_r.clock_source_select[rst_gate_pkg::CKS_LONG]) begin
            delay_sel = {delay_sel[rst_gate_pkg::CNT_W-2:0], 1'b0};
        end
        delay_m1 = delay_sel - 1'b1;
    end

    // ------------------------------------------------------------
    // Reset stretcher
    // ------------------------------------------------------------

    // Any source parks the machine in HOLD with the count cleared
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= rst_gate_pkg::ST_HOLD;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                rst_gate_pkg::ST_HOLD: begin
                    cnt_r <= '0;
                    if (!src_any) begin
                        state_r <= rst_gate_pkg::ST_COUNT;
                    end
                end
                rst_gate_pkg::ST_COUNT: begin
                    if (src_any) begin
                        state_r <= rst_gate_pkg::ST_HOLD;
                        cnt_r   <= '0;
                    end else if (cnt_r >= delay_m1) begin
                        state_r <= rst_gate_pkg::ST_RUN;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                rst_gate_pkg::ST_RUN: begin
                    cnt_r <= '0;
                    if (src_any) begin
                        state_r <= rst_gate_pkg::ST_HOLD;
                    end
                end
                default: begin
                    state_r <= rst_gate_pkg::ST_HOLD;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    // Start strobe tells the core to fetch from the reset vector
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vec_r <= 1'b0;
        end else begin
            vec_r <= (state_r == rst_gate_pkg::ST_COUNT) && !src_any
                     && (cnt_r >= delay_m1);
        end
    end
    assign vector_start_o = vec_r;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------

    // Zero wait states; an unmapped access errors in its access phase
    assign mapped = (paddr_i == rst_gate_pkg::PCG_OFF)
                 || (paddr_i == rst_gate_pkg::CFG_OFF)
                 || (paddr_i == rst_gate_pkg::STAT_OFF);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign wr_en     = psel_i & penable_i & pwrite_i;

    // Gate register: forced clear by any internal reset
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pcg_r <= rst_gate_pkg::PCG_RESET;
        end else if (stretch || async_src) begin
            pcg_r <= rst_gate_pkg::PCG_RESET;
        end else if (wr_en && paddr_i == rst_gate_pkg::PCG_OFF) begin
            pcg_r <= pwdata_i[7:0];
        end
    end

    // Config acts like fuses: survives stretched resets
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_r <= rst_gate_pkg::CFG_RESET;
        end else if (wr_en && paddr_i == rst_gate_pkg::CFG_OFF) begin
            cfg_r <= pwdata_i[$bits(rst_gate_pkg::cfg_type)-1:0];
        end
    end

    // Status word shows live sources, stretcher and gates
    always_comb begin
        stat_word = '0;
        stat_word[rst_gate_pkg::ST_SRC_LSB +: 4] = sync_r;
        stat_word[rst_gate_pkg::ST_BUSY] = stretch;
        stat_word[rst_gate_pkg::ST_GATE_LSB +: 8] = gate_stop;
    end

    // Read data is captured in the setup phase
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_r <= '0;
        end else if (psel_i && !penable_i) begin
            case (paddr_i)
                rst_gate_pkg::PCG_OFF:  prdata_r <= {24'h000000, pcg_r};
                rst_gate_pkg::CFG_OFF:  prdata_r <= {23'h000000, cfg_r};
                rst_gate_pkg::STAT_OFF: prdata_r <= stat_word;
                default:                prdata_r <= '0;
            endcase
        end
    end
    assign prdata_o = prdata_r;

    // ------------------------------------------------------------
    // Peripheral gating
    // ------------------------------------------------------------

    // Enables stop the clock and register access only; module state is never touched,
    // so a regated module carries on where it stopped
    always_comb begin
        gate_stop = pcg_r;
        gate_stop[rst_gate_pkg::BIT_ASYNC_TMR] =
            pcg_r[rst_gate_pkg::BIT_ASYNC_TMR]
            & ~timer_async_clock_select_i;
    end
    assign clk_en_o        = ~gate_stop;
    assign reg_access_en_o = ~gate_stop;

    // Comparator loses the shared multiplexer while converter is off
    assign comparator_mux_en_o = ~pcg_r[rst_gate_pkg::BIT_CONVERTER];

    // Reference runs whenever any of its three users wants it
    assign bandgap_en_o = bod_on | comparator_bandgap_select_i
                        | converter_enable_i;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    gate_twi_a: assert property (pcg_r[7] |-> !clk_en_o[7])
        else $error("two-wire clock runs while gated");

    async_tmr_a: assert property (
        clk_en_o[6] == !(pcg_r[6] && !timer_async_clock_select_i))
        else $error("async timer gate wrong");

    wide_tmr_a: assert property (pcg_r[3] |-> !clk_en_o[3] && !reg_access_en_o[3])
        else $error("wide timer not frozen");

    mux_deny_a: assert property (pcg_r[0] |-> !comparator_mux_en_o && !clk_en_o[0])
        else $error("comparator mux allowed with converter off");

    port_reset_a: assert property ((por_low_i || !ext_reset_n_i) |-> !io_reset_n_o)
        else $error("port reset missed a source");

    scan_hold_a: assert property (scan_reset_i |-> !internal_reset_n_o)
        else $error("reset released under scan reset");

    wdt_pulse_a: assert property (wdt_pulse_r |=> !wdt_pulse_r ##1 1)
        else $error("watchdog pulse wider than one cycle");

    count_clear_a: assert property (
        (state_r == rst_gate_pkg::ST_COUNT && src_any)
        |=> state_r == rst_gate_pkg::ST_HOLD && cnt_r == '0)
        else $error("delay not cleared by new source");

    wdt_start_a: assert property (
        $fell(wdt_pulse_r) && !(sync_r.por | sync_r.ext | sync_r.scan)
        && !(bod_on && sync_r.brownout_detector)
        |=> state_r == rst_gate_pkg::ST_COUNT && cnt_r == '0)
        else $error("delay not started at watchdog pulse end");

    release_a: assert property (
        (state_r == rst_gate_pkg::ST_COUNT && !src_any && cnt_r >= delay_m1)
        |=> state_r == rst_gate_pkg::ST_RUN && vector_start_o)
        else $error("stretcher did not release on time");

    hold_a: assert property (
        (state_r == rst_gate_pkg::ST_COUNT && cnt_r < delay_m1)
        |-> !internal_reset_n_o)
        else $error("reset released during delay");

    gate_clear_a: assert property (stretch |=> pcg_r == rst_gate_pkg::PCG_RESET)
        else $error("gate register survived reset");

    bandgap_a: assert property (
        bandgap_en_o == (bod_on || comparator_bandgap_select_i || converter_enable_i))
        else $error("bandgap enable mismatch");

endmodule // reset_and_module_clock_gating

// >>> verification/source_partner.sv
// Reset source detectors and peripheral levels facing the reset and gating block
`timescale 1ns/1ps

module source_partner (
    input  wire logic [8:0] cmd_i,
    input  wire logic [7:0] clk_en_i,
    output logic            por_low_o,
    output logic            ext_reset_n_o,
    output logic            bod_low_o,
    output logic            scan_reset_o,
    output logic            wdt_timeout_o,
    output logic            wdt_enable_o,
    output logic            async_sel_o,
    output logic            comparator_bandgap_select_o,
    output logic            conv_en_o
);
    // ------------------------------------------------------------
    // Detector levels, each held as long as the bench commands it
    // ------------------------------------------------------------
    assign por_low_o     = cmd_i[0];
    assign ext_reset_n_o = ~cmd_i[1];   // Pin is active low
    assign bod_low_o     = cmd_i[2];
    assign scan_reset_o  = cmd_i[3];
    assign wdt_timeout_o = cmd_i[4];
    assign wdt_enable_o  = cmd_i[5];
    assign async_sel_o   = cmd_i[6];
    assign comparator_bandgap_select_o        = cmd_i[7];
    // Software drops the converter enable as soon as its gate bit is set
    assign conv_en_o     = cmd_i[8] & clk_en_i[0];
endmodule // source_partner

// >>> verification/reset_and_module_clock_gating_tb_top.sv
// Self-checking bench for the reset combiner and clock gating block
`timescale 1ns/1ps

module reset_and_module_clock_gating_tb_top;
    localparam int DLY = 2 * rst_gate_pkg::CLK_MHZ; // Startup select 2 picks DELAY2_US = 2
    logic        sys_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er;
    logic        por_low, ext_n, bod_low, scan_rst, wdt_to, wdt_en, async_sel, comparator_bandgap_select, conv_en;
    logic        io_reset_n, int_reset_n, vec_start, mux_en, bandgap;
    logic [7:0]  clk_en, acc_en;
    logic [8:0]  cmd = 9'h000;
    int          fails = 0;
    int          comparisons = 0;
    int          n;

    // ------------------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------------------
    always #25 sys_clk_i = ~sys_clk_i;

    reset_and_module_clock_gating #(.DELAY0_US(1), .DELAY1_US(1), .DELAY2_US(2),
        .DELAY3_US(3)) dut_u (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .por_low_i(por_low), .ext_reset_n_i(ext_n),
        .bod_low_i(bod_low), .scan_reset_i(scan_rst), .wdt_timeout_i(wdt_to),
        .wdt_enable_i(wdt_en), .timer_async_clock_select_i(async_sel),
        .comparator_bandgap_select_i(comparator_bandgap_select), .converter_enable_i(conv_en),
        .io_reset_n_o(io_reset_n), .internal_reset_n_o(int_reset_n),
        .vector_start_o(vec_start), .clk_en_o(clk_en), .reg_access_en_o(acc_en),
        .comparator_mux_en_o(mux_en), .bandgap_en_o(bandgap));

    source_partner partner_u (
        .cmd_i(cmd), .clk_en_i(clk_en), .por_low_o(por_low), .ext_reset_n_o(ext_n),
        .bod_low_o(bod_low), .scan_reset_o(scan_rst), .wdt_timeout_o(wdt_to),
        .wdt_enable_o(wdt_en), .async_sel_o(async_sel), .comparator_bandgap_select_o(comparator_bandgap_select), .conv_en_o(conv_en));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; an idle cycle first keeps each signal to one assignment per step
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge sys_clk_i);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        while (pready !== 1'b1 && k < 50) begin
            k++;
            @(posedge sys_clk_i);
        end
        if (k == 50) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Counts edges until internal reset lifts, then checks the start pulse
    task automatic count_release();
        n = 0;
        do begin
            @(posedge sys_clk_i); #1;
            n++;
        end while (int_reset_n !== 1'b1 && n < 2000);
        check("stretch_long", 32'(n >= DLY && n <= DLY + 6), 32'h1);
        check("vector_pulse", 32'(vec_start), 32'h1);
        @(posedge sys_clk_i); #1;
        check("vector_single", 32'(vec_start), 32'h0);
    endtask

    // Asserts one pin source, releases it, optionally re-fires power-on during the stretch
    task automatic src_reset(input int idx, input bit again);
        apb(rst_gate_pkg::PCG_OFF, 1'b1, 32'h28);
        @(posedge sys_clk_i);
        cmd[idx] <= 1'b1;
        #1;
        check("internal_low", 32'(int_reset_n), 32'h0);
        check("io_low", 32'(io_reset_n), 32'h0);
        repeat (4) @(posedge sys_clk_i);
        check("held_by_source", 32'(int_reset_n), 32'h0);
        cmd[idx] <= 1'b0;
        if (again) begin
            repeat (12) @(posedge sys_clk_i);
            cmd[0] <= 1'b1;
            repeat (3) @(posedge sys_clk_i);
            cmd[0] <= 1'b0;
        end
        count_release();
        apb(rst_gate_pkg::PCG_OFF, 1'b0, 32'h0);
        check("gate_cleared", rd, 32'h0);
    endtask

    task automatic finish_test();
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog against a hang, sized well above the expected run
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fails++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        count_release();
        apb(rst_gate_pkg::PCG_OFF, 1'b0, 32'h0);
        check("gate_reset", rd, 32'h0);
        check("clk_en_reset", 32'(clk_en), 32'hff);
        apb(rst_gate_pkg::CFG_OFF, 1'b0, 32'h0);
        check("cfg_reset", rd, 32'h1c2);
        apb(8'h0c, 1'b0, 32'h0);
        check("unmapped_err", {rd[30:0], er}, 32'h1);
        // Each gate bit alone stops exactly its own peripheral
        for (int b = 0; b < 8; b++) begin
            apb(rst_gate_pkg::PCG_OFF, 1'b1, 32'(8'h01 << b));
            @(posedge sys_clk_i); #1;
            check("clk_en_bit", 32'(clk_en), {24'h000000, ~(8'h01 << b)});
            check("access_bit", 32'(acc_en), {24'h000000, ~(8'h01 << b)});
            check("mux_en", 32'(mux_en), 32'(b != 0));
            apb(rst_gate_pkg::PCG_OFF, 1'b0, 32'h0);
            check("gate_readback", rd, 32'(8'h01 << b));
            apb(rst_gate_pkg::STAT_OFF, 1'b0, 32'h0);
            check("status_gate", rd, {16'h0000, 8'h01 << b, 8'h00});
        end
        // Asynchronous timer mode keeps that timer clocked despite its bit
        @(posedge sys_clk_i);
        cmd[6] <= 1'b1;
        apb(rst_gate_pkg::PCG_OFF, 1'b1, 32'h40);
        @(posedge sys_clk_i); #1;
        check("async_runs", 32'(clk_en), 32'hff);
        apb(rst_gate_pkg::PCG_OFF, 1'b1, 32'h00);
        @(posedge sys_clk_i); #1;
        check("all_resume", 32'(clk_en), 32'hff);
        // Bandgap needs and the disabled brown-out level; levels change on the edge
        @(posedge sys_clk_i);
        cmd <= 9'h004;
        repeat (4) @(posedge sys_clk_i); #1;
        check("bod_ignored", 32'(int_reset_n), 32'h1);
        check("bandgap_off", 32'(bandgap), 32'h0);
        @(posedge sys_clk_i);
        cmd <= 9'h080;
        @(posedge sys_clk_i); #1;
        check("bandgap_comparator_bandgap_select", 32'(bandgap), 32'h1);
        @(posedge sys_clk_i);
        cmd <= 9'h100;
        @(posedge sys_clk_i); #1;
        check("bandgap_conv", 32'(bandgap), 32'h1);
        @(posedge sys_clk_i);
        cmd <= 9'h000;
        apb(rst_gate_pkg::CFG_OFF, 1'b1, 32'h102);
        @(posedge sys_clk_i); #1;
        check("bandgap_bod", 32'(bandgap), 32'h1);
        // Every pin source, then a power-on restart inside the stretch
        for (int s = 0; s < 4; s++) src_reset(s, 1'b0);
        src_reset(1, 1'b1);
        // Watchdog expiry ignored while disabled, a stretched reset while enabled
        for (int e = 0; e < 2; e++) begin
            @(posedge sys_clk_i);
            cmd[5] <= e[0];
            cmd[4] <= 1'b1;
            @(posedge sys_clk_i);
            cmd[4] <= 1'b0;
            #1;
            check("wdt_reset", 32'(int_reset_n), 32'(e == 0));
            if (e == 1) count_release();
        end
        finish_test();
    end
endmodule // reset_and_module_clock_gating_tb_top
